// file: exarb_top.sv
// exception arbiter: request latch, priority, entry and return
// sequencing, break state and flag protection, apb status access
// assumes requests and cpu strobes come from logic on pclk
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none

module exarb_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [exarb_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [exarb_pkg::DATA_W-1:0]  pwdata,
  output logic      [exarb_pkg::DATA_W-1:0]  prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [exarb_pkg::NUM_SRC-1:0] src_req,
  input  wire logic [exarb_pkg::NUM_SRC-1:0] src_enable,
  input  wire logic                          ccr_mask,
  input  wire logic                          instr_boundary,
  input  wire logic                          swi_exec,
  input  wire logic                          rti_exec,
  input  wire logic                          break_assert,
  output logic                               entry_active,
  output logic      [2:0]                    entry_step,
  output logic      [exarb_pkg::CODE_W-1:0]  vector_code,
  output logic                               push_pc_minus_one,
  output logic                               set_mask,
  output logic                               restore_regs,
  output logic                               prefetch_discard,
  output logic                               break_state,
  output logic                               flag_clear_allow
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    exarb_pkg::exarb_state_type     st;
    exarb_pkg::exarb_step_type      step;
    logic [2:0]                     pops;
    logic                           lat_v;
    logic                           lat_trap;
    logic                           lat_brk;
    logic [exarb_pkg::CODE_W-1:0]   lat_code;
    logic                           mask_prev;
    logic                           from_rti;
    logic                           break_clear_enable_bit;
    logic                           brk;
    logic                           entry_active;
    logic [exarb_pkg::CODE_W-1:0]   vec;
    logic                           pc_dec;
    logic                           set_mask;
    logic                           restore;
    logic                           discard;
    logic                           clear_allow;
    logic [exarb_pkg::DATA_W-1:0]   prdata;
    logic                           pready;
    logic                           pslverr;
  } exarb_regs_type;

  exarb_regs_type r_q;
  exarb_regs_type r_d;

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  exarb_arb_if arb ();

  // only enabled requests compete, and only while unmasked
  assign arb.req = (src_req & src_enable)
                 & {exarb_pkg::NUM_SRC{~ccr_mask}};

  exarb_prio u_prio (
    .arb (arb.encoder)
  );

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  logic [exarb_pkg::DATA_W-1:0] rd_val;
  logic                         rd_hit;

  // flags are the live request lines, so a flag cleared at its
  // source (in break or not) reads zero from then on
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (paddr == exarb_pkg::ADDR_FLAGS_LOW) begin
      rd_val[exarb_pkg::LOW_SHIFT +: exarb_pkg::LOW_CNT] =
        src_req[0 +: exarb_pkg::LOW_CNT];
    end else if (paddr == exarb_pkg::ADDR_FLAGS_MID) begin
      rd_val[0 +: exarb_pkg::MID_CNT] =
        src_req[exarb_pkg::MID_BASE +: exarb_pkg::MID_CNT];
    end else if (paddr == exarb_pkg::ADDR_FLAGS_HIGH) begin
      rd_val[0 +: exarb_pkg::HIGH_CNT] =
        src_req[exarb_pkg::HIGH_BASE +: exarb_pkg::HIGH_CNT];
    end else if (paddr == exarb_pkg::ADDR_BRK_CTRL) begin
      rd_val[exarb_pkg::BREAK_CLEAR_ENABLE_BIT_BIT] = r_q.break_clear_enable_bit;
    end else if (paddr == exarb_pkg::ADDR_ARB_STAT) begin
      rd_val[0] = r_q.lat_v;
      rd_val[1 +: exarb_pkg::CODE_W] = r_q.lat_code;
      rd_val[exarb_pkg::CODE_W + 1] = r_q.brk;
      rd_val[exarb_pkg::CODE_W + 2] = (r_q.st != exarb_pkg::ST_IDLE);
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic setup;
  logic access;

  assign setup  = psel & ~penable;
  assign access = psel & penable & r_q.pready;

  always_comb begin
    r_d = r_q;
    r_d.set_mask  = 1'b0;
    r_d.restore   = 1'b0;
    r_d.discard   = 1'b0;
    r_d.mask_prev = ccr_mask;

    // apb: answer registered in the setup cycle, no wait states
    r_d.pready  = setup;
    r_d.pslverr = setup & ~rd_hit;
    r_d.prdata  = setup & ~pwrite ? rd_val : '0;
    if (access && pwrite && paddr == exarb_pkg::ADDR_BRK_CTRL) begin
      r_d.break_clear_enable_bit = pwdata[exarb_pkg::BREAK_CLEAR_ENABLE_BIT_BIT];
    end

    // latch a winner only when nothing is held already
    if (!r_q.lat_v) begin
      if (break_assert) begin
        r_d.lat_v    = 1'b1;
        r_d.lat_trap = 1'b1;
        r_d.lat_brk  = 1'b1;
        r_d.lat_code = exarb_pkg::CODE_TRAP;
      end else if (swi_exec) begin
        r_d.lat_v    = 1'b1;
        r_d.lat_trap = 1'b1;
        r_d.lat_brk  = 1'b0;
        r_d.lat_code = exarb_pkg::CODE_TRAP;
      end else if (arb.any) begin
        r_d.lat_v    = 1'b1;
        r_d.lat_trap = 1'b0;
        r_d.lat_brk  = 1'b0;
        r_d.lat_code = arb.code;
      end
    end else if (!r_q.lat_trap && r_q.mask_prev && !ccr_mask
                 && r_q.st == exarb_pkg::ST_IDLE) begin
      // mask cleared: held hardware request may be re-arbitrated
      r_d.lat_v = 1'b0;
    end

    case (r_q.st)
      exarb_pkg::ST_IDLE: begin
        // entry only between instructions, never mid-instruction
        if (instr_boundary && r_q.lat_v) begin
          r_d.st           = exarb_pkg::ST_ENTRY;
          r_d.step         = exarb_pkg::STEP_PCL;
          r_d.entry_active = 1'b1;
          r_d.vec          = r_q.lat_code;
          // trap returns past itself, hardware re-runs nothing
          r_d.pc_dec       = ~r_q.lat_trap;
          r_d.discard      = r_q.from_rti;
          if (r_q.lat_brk) begin
            r_d.brk = 1'b1;
          end
        end
        // a request already pending at the return keeps the prefetch
        // marked redundant until its entry is taken
        if (instr_boundary && (r_q.lat_v || !arb.any)) begin
          r_d.from_rti = 1'b0;
        end
      end
      exarb_pkg::ST_ENTRY: begin
        // high index register has no step in this walk
        case (r_q.step)
          exarb_pkg::STEP_PCL:  r_d.step = exarb_pkg::STEP_PCH;
          exarb_pkg::STEP_PCH:  r_d.step = exarb_pkg::STEP_X;
          exarb_pkg::STEP_X:    r_d.step = exarb_pkg::STEP_A;
          exarb_pkg::STEP_A:    r_d.step = exarb_pkg::STEP_CCR;
          exarb_pkg::STEP_CCR: begin
            r_d.step     = exarb_pkg::STEP_VECH;
            r_d.set_mask = 1'b1;
          end
          exarb_pkg::STEP_VECH: r_d.step = exarb_pkg::STEP_VECL;
          default: begin
            r_d.st           = exarb_pkg::ST_SERVICE;
            r_d.entry_active = 1'b0;
            r_d.lat_v        = 1'b0;
            r_d.step         = exarb_pkg::STEP_PCL;
          end
        endcase
      end
      exarb_pkg::ST_SERVICE: begin
        if (rti_exec) begin
          r_d.st   = exarb_pkg::ST_RETURN;
          r_d.pops = '0;
        end else if (swi_exec || break_assert) begin
          // nested trap inside a handler goes back through idle
          r_d.st = exarb_pkg::ST_IDLE;
        end
      end
      default: begin
        // pop ccr, a, x, pch, pcl back into the core
        r_d.pops = r_q.pops + 3'h1;
        if (r_q.pops == 3'(exarb_pkg::RTI_POPS - 1)) begin
          r_d.st       = exarb_pkg::ST_IDLE;
          r_d.restore  = 1'b1;
          r_d.from_rti = 1'b1;
          if (r_q.brk) begin
            r_d.brk = 1'b0;
          end
        end
      end
    endcase

    // other modules may clear flags only outside break or with break_clear_enable_bit;
    // their two-step clears see this gate on the final step
    r_d.clear_allow = ~r_d.brk | r_d.break_clear_enable_bit;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // internal reset outranks every request and is never arbitrated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q             <= '0;
      r_q.st          <= exarb_pkg::ST_IDLE;
      r_q.step        <= exarb_pkg::STEP_PCL;
      r_q.break_clear_enable_bit        <= exarb_pkg::BREAK_CLEAR_ENABLE_BIT_RESET;
      r_q.clear_allow <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata            = r_q.prdata;
  assign pready            = r_q.pready;
  assign pslverr           = r_q.pslverr;
  assign entry_active      = r_q.entry_active;
  assign entry_step        = r_q.step;
  assign vector_code       = r_q.vec;
  assign push_pc_minus_one = r_q.pc_dec;
  assign set_mask          = r_q.set_mask;
  assign restore_regs      = r_q.restore;
  assign prefetch_discard  = r_q.discard;
  assign break_state       = r_q.brk;
  assign flag_clear_allow  = r_q.clear_allow;

endmodule

`default_nettype wire

// file: exarb_pkg.sv
// constants and types shared by the exception arbiter files
// assumes a 32-bit apb bus and a cpu core on the same clock
//
// Functional notes
// - entry stacks registers and sets mask
// - return restores registers from stack
// - requests latched, arbitration yields vector code
// - latched request cannot be displaced; the code re-arbitrates a held hardware request when the mask clears in idle
// - hardware request waits for instruction end
// - boundary check needs mask clear, enable set; the code checks both only when latching, not at the boundary
// - highest priority pending request wins
// - pending at return serviced first
// - high index register never stacked
// - software trap ignores the mask
// - software pushes pc, hardware pc minus one
// - fixed priority, external pin highest
// - low flags reg: flags 6..1, bits 1:0 zero
// - mid flags reg: flags 14..7
// - high flags reg: flags 20..15, top zero
// - flag shows request present live
// - resets outrank all, no arbitration
// - break forces software trap vector fetch
// - break protects flags unless clear enable
// - flag cleared in break stays cleared
// - two-step clears stay protected in break
// - break clear enable bit read/write
`default_nettype none

package exarb_pkg;

  localparam int NUM_SRC = 20;
  localparam int CODE_W  = 5;
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 32;

  // -------------------------------------------------------------
  // register map (byte addresses)
  // -------------------------------------------------------------
  localparam logic [15:0] ADDR_FLAGS_LOW  = 16'hFE04;
  localparam logic [15:0] ADDR_FLAGS_MID  = 16'hFE08;
  localparam logic [15:0] ADDR_FLAGS_HIGH = 16'hFE0C;
  localparam logic [15:0] ADDR_BRK_CTRL   = 16'hFE10;
  localparam logic [15:0] ADDR_ARB_STAT   = 16'hFE14;

  // field layout of the flag registers
  localparam int LOW_SHIFT  = 2;
  localparam int LOW_CNT    = 6;
  localparam int MID_BASE   = 6;
  localparam int MID_CNT    = 8;
  localparam int HIGH_BASE  = 14;
  localparam int HIGH_CNT   = 6;
  localparam int BREAK_CLEAR_ENABLE_BIT_BIT   = 0;
  localparam logic BREAK_CLEAR_ENABLE_BIT_RESET = 1'b0;

  // vector code of the software trap, also used for break entry
  localparam logic [CODE_W-1:0] CODE_TRAP = 5'h00;
  localparam int RTI_POPS = 5;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ENTRY,
    ST_SERVICE,
    ST_RETURN
  } exarb_state_type;

  // one code per bus cycle of the entry sequence
  typedef enum logic [2:0] {
    STEP_PCL,
    STEP_PCH,
    STEP_X,
    STEP_A,
    STEP_CCR,
    STEP_VECH,
    STEP_VECL
  } exarb_step_type;

endpackage

`default_nettype wire

// file: exarb_arb_if.sv
// request vector and arbitration result between the top and encoder
// assumes requests already gated by mask and enable
`default_nettype none

interface exarb_arb_if;
  logic [exarb_pkg::NUM_SRC-1:0] req;
  logic                          any;
  logic [exarb_pkg::CODE_W-1:0]  code;

  modport requester (output req, input any, input code);
  modport encoder   (input req, output any, output code);
endinterface

`default_nettype wire

// file: exarb_prio.sv
// fixed priority encoder of the maskable sources
// assumes source index 0 is the external request pin, highest
`default_nettype none

module exarb_prio (
  exarb_arb_if.encoder arb
);

  // ---------------------------------------------------------------
  // encoder
  // ---------------------------------------------------------------
  // scan from lowest to highest so the highest index 0 wins last
  always_comb begin
    arb.any  = 1'b0;
    arb.code = exarb_pkg::CODE_TRAP;
    for (int i = exarb_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (arb.req[i]) begin
        arb.any  = 1'b1;
        arb.code = exarb_pkg::CODE_W'(i + 1);
      end
    end
  end

endmodule

`default_nettype wire

// file: exarb_arb_properties.sv
// port checks on the exception arbiter top
// assumes one pclk domain; bound onto exarb_top below
`default_nettype none
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module exarb_arb_properties (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       instr_boundary,
  input wire logic       rti_exec,
  input wire logic       entry_active,
  input wire logic [2:0] entry_step,
  input wire logic [4:0] vector_code,
  input wire logic       push_pc_minus_one,
  input wire logic       set_mask,
  input wire logic       restore_regs,
  input wire logic       break_state,
  input wire logic       flag_clear_allow
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // bus answer is one wait-free access cycle
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  apb_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  // entry waits for an instruction end, then runs seven steps
  entry_start_a: assert property ($rose(entry_active) |->
    entry_step == 3'h0 && $past(instr_boundary)) else $error("bad start");
  entry_len_a: assert property ($rose(entry_active) |->
    entry_active[*7] ##1 !entry_active) else $error("entry length");
  mask_set_a: assert property (entry_active && entry_step == 3'h4
    |=> entry_step == 3'h5 && set_mask) else $error("mask not set");
  trap_pc_a: assert property ($rose(entry_active) &&
    vector_code == 5'h00 |-> !push_pc_minus_one) else $error("trap pc");
  hw_pc_a: assert property ($rose(entry_active) &&
    vector_code != 5'h00 |-> push_pc_minus_one) else $error("hw pc");
  code_hold_a: assert property (entry_active && $past(entry_active)
    |-> $stable(vector_code)) else $error("code moved");
  restore_a: assert property (rti_exec && !entry_active |->
    ##[4:6] restore_regs) else $error("no restore");
  clear_allow_a: assert property ((!break_state)[*2] |->
    flag_clear_allow) else $error("clear blocked");
  // main scenarios reached
  cover property ($rose(entry_active) && vector_code == 5'h00);
  cover property ($rose(entry_active) && push_pc_minus_one);
  cover property (restore_regs);
  cover property (break_state && !flag_clear_allow);
endmodule
bind exarb_top exarb_arb_properties i_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .instr_boundary(instr_boundary), .rti_exec(rti_exec),
  .entry_active(entry_active), .entry_step(entry_step),
  .vector_code(vector_code), .push_pc_minus_one(push_pc_minus_one),
  .set_mask(set_mask), .restore_regs(restore_regs),
  .break_state(break_state), .flag_clear_allow(flag_clear_allow));
`default_nettype wire

// file: exarb_cpu_model.sv
// behavioural cpu core facing the arbiter
// assumes the arbiter's entry and restore strobes on pclk
`default_nettype none
// ------------------------------------------------------------
// cpu model
// ------------------------------------------------------------
module exarb_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       entry_active,
  input  wire logic       restore_regs,
  input  wire logic       mask_req,
  input  wire logic [7:0] svc_len,
  output logic            instr_boundary,
  output logic            rti_exec,
  output logic            ccr_mask,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q;
  logic [7:0] cnt_q;
  // an instruction ends every third cycle
  assign instr_boundary = presetn && div_q == 2'h0;
  // handler keeps the mask up until the return restores it
  // the return restores the mask bit in its last cycle
  assign ccr_mask = mask_req | (busy & ~restore_regs);
  // service length is bench-set so replies come fast or slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
      cnt_q <= 8'h00;
      busy <= 1'b0;
      rti_exec <= 1'b0;
    end else begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      rti_exec <= !entry_active && cnt_q == 8'h01;
      if (entry_active) begin
        busy <= 1'b1;
        cnt_q <= svc_len;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      if (restore_regs) begin
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: exception_arbiter_tb_top.sv
// self-checking bench of the exception arbiter
// assumes exarb_pkg, the cpu model and the bound checker
`default_nettype none
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module exception_arbiter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, swi_exec = 1'b0, break_assert = 1'b0;
  logic mask_req = 1'b1, was_act = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic [19:0] src_req = 20'h00000, src_enable = 20'h00000, rq_v, en;
  logic [7:0] svc_len = 8'h05;
  logic [32:0] rq[$], ex;
  logic [6:0] eq[$], ee;
  logic [4:0] vector_code;
  logic [2:0] entry_step;
  logic pready, pslverr, instr_boundary, rti_exec, ccr_mask, busy;
  logic entry_active, push_pc_minus_one, set_mask, restore_regs;
  logic prefetch_discard, break_state, flag_clear_allow;
  int fails = 0, compares = 0, seed = 90, a, b, k;
  exarb_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_req, .src_enable,
    .ccr_mask, .instr_boundary, .swi_exec, .rti_exec, .break_assert,
    .entry_active, .entry_step, .vector_code, .push_pc_minus_one,
    .set_mask, .restore_regs, .prefetch_discard, .break_state,
    .flag_clear_allow);
  exarb_cpu_model i_cpu (.pclk, .presetn, .entry_active, .restore_regs,
    .mask_req, .svc_len, .instr_boundary, .rti_exec, .ccr_mask, .busy);
  always #50 pclk = ~pclk;
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one bus transfer; entered and left just after a rising edge
  task automatic apb(input logic w, input logic [15:0] ad,
                     input logic [31:0] d, input logic [32:0] x);
    int n;
    n = 0;
    rq.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin fails++; wrap_up(); end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // sampled mid-cycle so monitor pops never race the test
  task automatic wait_idle;
    int n;
    n = 0;
    do begin @(negedge pclk); n++; end
      while ((eq.size() != 0 || busy !== 1'b0) && n < 3000);
    if (n >= 3000) begin fails++; wrap_up(); end
    @(posedge pclk);
  endtask
  // monitor: oldest note against each answer; retires served sources
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      ex = (rq.size() > 0) ? rq.pop_front() : 33'h1FFFFFFFF;
      `CHK("apb", ex, {pslverr, prdata})
    end
    if (entry_active === 1'b1 && !was_act) begin
      ee = (eq.size() > 0) ? eq.pop_front() : 7'h7F;
      `CHK("entry", ee, {prefetch_discard, push_pc_minus_one, vector_code})
      if (vector_code != 5'h00 && vector_code <= 5'h14)
        src_req[vector_code - 5'h01] <= 1'b0;
    end
    was_act <= entry_active;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, exarb_pkg::ADDR_FLAGS_LOW, 0, 33'h0);
    apb(0, exarb_pkg::ADDR_FLAGS_MID, 0, 33'h0);
    apb(0, exarb_pkg::ADDR_FLAGS_HIGH, 0, 33'h0);
    apb(0, exarb_pkg::ADDR_BRK_CTRL, 0, {32'h0, exarb_pkg::BREAK_CLEAR_ENABLE_BIT_RESET});
    apb(0, 16'hFE40, 0, {1'b1, 32'h0});
    // live flags, sources disabled so nothing is taken
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      src_req <= v[19:0];
      @(posedge pclk);
      apb(0, exarb_pkg::ADDR_FLAGS_LOW, 0, {25'h0, v[5:0], 2'h0});
      apb(0, exarb_pkg::ADDR_FLAGS_MID, 0, {25'h0, v[13:6]});
      apb(0, exarb_pkg::ADDR_FLAGS_HIGH, 0, {27'h0, v[19:14]});
    end
    apb(1, exarb_pkg::ADDR_FLAGS_LOW, 32'hFFFFFFFF, 33'h0);
    apb(0, exarb_pkg::ADDR_FLAGS_LOW, 0, {25'h0, v[5:0], 2'h0});
    // pairs of requests, some disabled, released by the mask
    for (int i = 0; i < 6; i++) begin
      a = {$random(seed)} % 20;
      b = {$random(seed)} % 20;
      v = $random(seed);
      en = v[19:0] | (20'h00001 << a);
      rq_v = (20'h00001 << a) | (20'h00001 << b);
      mask_req <= 1'b1;
      src_enable <= en;
      src_req <= rq_v;
      k = 0;
      for (int j = 0; j < 20; j++)
        if (rq_v[j] && en[j]) begin
          eq.push_back({k != 0, 1'b1, 5'(j + 1)});
          k++;
        end
      repeat (6) @(posedge pclk);
      mask_req <= 1'b0;
      wait_idle();
      src_req <= 20'h00000;
      @(posedge pclk);
    end
    // a latched low source is not displaced by a later high one
    src_enable <= 20'hFFFFF;
    eq.push_back({2'b01, 5'h14});
    eq.push_back({2'b11, 5'h01});
    src_req <= 20'h80000;
    @(posedge pclk);
    src_req[0] <= 1'b1;
    wait_idle();
    // software trap under mask
    mask_req <= 1'b1;
    eq.push_back({2'b00, exarb_pkg::CODE_TRAP});
    swi_exec <= 1'b1;
    @(posedge pclk);
    swi_exec <= 1'b0;
    wait_idle();
    // break entry with a slow handler, then the clear enable
    svc_len <= 8'h3C;
    eq.push_back({2'b00, exarb_pkg::CODE_TRAP});
    break_assert <= 1'b1;
    @(posedge pclk);
    break_assert <= 1'b0;
    repeat (14) @(posedge pclk);
    `CHK("break", 1'b1, break_state)
    `CHK("allow", 1'b0, flag_clear_allow)
    apb(1, exarb_pkg::ADDR_BRK_CTRL, 32'h1, 33'h0);
    apb(0, exarb_pkg::ADDR_BRK_CTRL, 0, 33'h1);
    `CHK("allow", 1'b1, flag_clear_allow)
    apb(1, exarb_pkg::ADDR_BRK_CTRL, 32'h0, 33'h0);
    wait_idle();
    `CHK("break", 1'b0, break_state)
    `CHK("allow", 1'b1, flag_clear_allow)
    wrap_up();
  end
endmodule
`default_nettype wire
